/* File: csr_defines.svh */
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CSR_CLK_PERIOD_NS     100
`define CSR_UI_NS             400
`define CSR_CLK_SETTLE_MIN_NS 95
`define CSR_CLK_SETTLE_MAX_NS 300
`define CSR_HS_SETTLE_MIN_NS  (85 + 6 * `CSR_UI_NS)
`define CSR_HS_SETTLE_MAX_NS  (145 + 10 * `CSR_UI_NS)
// least times round up to whole cycles
`define CSR_CLK_SETTLE_CYC    ((`CSR_CLK_SETTLE_MIN_NS + `CSR_CLK_PERIOD_NS - 1) / `CSR_CLK_PERIOD_NS)
`define CSR_HS_SETTLE_CYC     ((`CSR_HS_SETTLE_MIN_NS + `CSR_CLK_PERIOD_NS - 1) / `CSR_CLK_PERIOD_NS)

// ----------------------------------------
// line states and sync pattern
// ----------------------------------------
`define CSR_LP11     2'h3
`define CSR_LP01     2'h1
`define CSR_LP00     2'h0
`define CSR_SYNC     8'hB8

// ----------------------------------------
// error status bits and reset value
// ----------------------------------------
`define CSR_ERR_CTRL 0
`define CSR_ERR_SOT  1
`define CSR_ERR_RST  2'h0

// ----------------------------------------
// video data-type codes
// ----------------------------------------
`define CSR_DT_RGB444   6'h20
`define CSR_DT_RGB555   6'h21
`define CSR_DT_RGB565   6'h22
`define CSR_DT_RGB666   6'h23
`define CSR_DT_RGB888   6'h24
`define CSR_DT_RAW6     6'h28
`define CSR_DT_RAW7     6'h29
`define CSR_DT_RAW8     6'h2A
`define CSR_DT_RAW10    6'h2B
`define CSR_DT_RAW12    6'h2C
`define CSR_DT_RAW14    6'h2D
`define CSR_DT_YUV420_8 6'h18
`define CSR_DT_YUV420_A 6'h19
`define CSR_DT_LEGACY8  6'h1A
`define CSR_DT_YUV420_S 6'h1C
`define CSR_DT_YUV420_T 6'h1D
`define CSR_DT_YUV422_8 6'h1E
`define CSR_DT_YUV422_A 6'h1F
`define CSR_DT_USER_LO  6'h30
`define CSR_DT_USER_HI  6'h37

`endif

/* File: csr_pkg.sv */
package csr_pkg;
	typedef enum logic [2:0] {
		LS_STOP,
		LS_REQ,
		LS_BRIDGE,
		LS_HUNT,
		LS_DATA,
		LS_FAULT
	} csr_lane_state_t;

	typedef logic [5:0] csr_dtype_t;
	typedef logic [1:0] csr_lp_t;
endpackage

/* File: csr_lane_fsm.sv */
`timescale 1ns/1ps
`include "csr_defines.svh"
module csr_lane_fsm #(
	parameter int        SETTLE_CYC = 1,
	parameter bit        HUNT_SYNC  = 1'b1
) (
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          ce,
	input  wire csr_pkg::csr_lp_t lp,
	input  wire logic          hsBit,
	input  wire logic          bitStrobe,
	input  wire logic          allowHs,
	output logic               hsActive,
	output logic [7:0]         laneByte,
	output logic               byteValid,
	output logic               ctrlErr,
	output logic               sotErr
);
	import csr_pkg::*;

	csr_lane_state_t state_q, state_d;
	logic [7:0]      cnt_q, cnt_d;
	logic [7:0]      shift_q, shift_d;
	logic [2:0]      bits_q, bits_d;
	logic [7:0]      shiftNext;

	assign shiftNext = {hsBit, shift_q[7:1]};
	assign hsActive  = (state_q == LS_DATA);
	assign laneByte  = shift_q;

	always_comb
	begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		shift_d   = shift_q;
		bits_d    = bits_q;
		byteValid = 1'b0;
		ctrlErr   = 1'b0;
		sotErr    = 1'b0;
		unique case (state_q)
			LS_STOP:
			begin
				if (lp == `CSR_LP01)
					state_d = LS_REQ;
				else if (lp != `CSR_LP11)
				begin
					ctrlErr = 1'b1;
					state_d = LS_FAULT;
				end
			end
			LS_REQ:
			begin
				cnt_d = '0;
				if (lp == `CSR_LP00)
					state_d = LS_BRIDGE;
				else if (lp == `CSR_LP11)
					state_d = LS_STOP;
				else if (lp != `CSR_LP01)
				begin
					ctrlErr = 1'b1;
					state_d = LS_FAULT;
				end
			end
			LS_BRIDGE:
			begin
				// HS bits are ignored until the settle window has run; LP-11 still aborts at once
				cnt_d   = cnt_q + 8'h01;
				shift_d = '0;
				bits_d  = '0;
				if (lp == `CSR_LP11)
				begin
					ctrlErr = 1'b1;
					state_d = LS_STOP;
				end
				else if (cnt_q >= 8'(SETTLE_CYC - 1) && allowHs)
					state_d = HUNT_SYNC ? LS_HUNT : LS_DATA;
			end
			LS_HUNT:
			begin
				if (lp == `CSR_LP11)
				begin
					sotErr  = 1'b1;
					state_d = LS_STOP;
				end
				else if (bitStrobe)
				begin
					shift_d = shiftNext;
					if (shiftNext == `CSR_SYNC)
						state_d = LS_DATA;
				end
			end
			LS_DATA:
			begin
				if (lp == `CSR_LP11)
					state_d = LS_STOP;
				else if (bitStrobe && HUNT_SYNC)
				begin
					shift_d = shiftNext;
					bits_d  = bits_q + 3'h1;
				end
				byteValid = HUNT_SYNC && (bits_q == 3'h0) && (cnt_q == 8'h01);
				cnt_d     = {7'h00, bitStrobe && (bits_q == 3'h7)};
			end
			LS_FAULT:
			begin
				if (lp == `CSR_LP11)
					state_d = LS_STOP;
			end
			default:
				state_d = LS_FAULT;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= LS_STOP;
			cnt_q   <= 8'h00;
			shift_q <= 8'h00;
			bits_q  <= 3'h0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			shift_q <= shift_d;
			bits_q  <= bits_d;
		end
	end
endmodule

/* File: csr_rx.sv */
`timescale 1ns/1ps
`include "csr_defines.svh"
module csr_rx #(
	parameter int LANES = 4
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic                 ce,
	input  wire logic                 linkClk,
	input  wire csr_pkg::csr_lp_t     clkLaneLp,
	input  wire logic [2*LANES-1:0]   dataLaneLp,
	input  wire logic [LANES-1:0]     dataLaneHs,
	input  wire csr_pkg::csr_dtype_t  typeSel,
	input  wire logic                 errClear,
	output logic [63:0]               pixelData,
	output logic                      pixelValid,
	output logic [3:0]                pixelCount,
	output logic                      hsync,
	output logic                      lineOdd,
	output logic                      clkLaneHs,
	output logic [1:0]                errStatus
);
	import csr_pkg::*;

	localparam int SW = 3 + 3 * LANES;
	localparam int AW = 128;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [SW-1:0] s1_q, s2_q;
	logic          linkPrev_q;
	logic [SW-1:0] rawIn;

	assign rawIn = {dataLaneHs, dataLaneLp, clkLaneLp, linkClk};

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q       <= '1;
			s2_q       <= '1;
			linkPrev_q <= 1'b1;
		end
		else if (ce)
		begin
			s1_q       <= rawIn;
			s2_q       <= s1_q;
			linkPrev_q <= s2_q[0];
		end
	end

	// both link clock edges carry a bit, one per unit interval
	logic bitStrobe;
	assign bitStrobe = s2_q[0] ^ linkPrev_q;

	// ----------------------------------------
	// lane sequencers
	// ----------------------------------------
	logic             clkActive;
	logic             clkCtrlErr;
	logic [LANES-1:0] laneActive, laneValid, laneCtrlErr, laneSotErr;
	logic [7:0]       laneByte [LANES];

	csr_lane_fsm #(
		.SETTLE_CYC (`CSR_CLK_SETTLE_CYC),
		.HUNT_SYNC  (1'b0)
	) u_clk_lane (
		.clk       (clk),
		.arst_n    (arst_n),
		.ce        (ce),
		.lp        (s2_q[2:1]),
		.hsBit     (1'b0),
		.bitStrobe (bitStrobe),
		.allowHs   (1'b1),
		.hsActive  (clkActive),
		.laneByte  (),
		.byteValid (),
		.ctrlErr   (clkCtrlErr),
		.sotErr    ()
	);

	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			// data lanes only leave settle while the clock lane runs
			csr_lane_fsm #(
				.SETTLE_CYC (`CSR_HS_SETTLE_CYC),
				.HUNT_SYNC  (1'b1)
			) u_data_lane (
				.clk       (clk),
				.arst_n    (arst_n),
				.ce        (ce),
				.lp        (s2_q[3+2*g +: 2]),
				.hsBit     (s2_q[3+2*LANES+g]),
				.bitStrobe (bitStrobe),
				.allowHs   (clkActive),
				.hsActive  (laneActive[g]),
				.laneByte  (laneByte[g]),
				.byteValid (laneValid[g]),
				.ctrlErr   (laneCtrlErr[g]),
				.sotErr    (laneSotErr[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// format table
	// ----------------------------------------
	function automatic logic [10:0] fmt(input csr_dtype_t t, input logic odd);
		// returns {pixels[3:0], bits[6:0]}
		unique case (t)
			`CSR_DT_RGB444:   fmt = {4'h4, 7'h30};
			`CSR_DT_RGB555:   fmt = {4'h4, 7'h3C};
			`CSR_DT_RGB565:   fmt = {4'h4, 7'h40};
			`CSR_DT_RGB666:   fmt = {4'h3, 7'h36};
			`CSR_DT_RGB888:   fmt = {4'h2, 7'h30};
			`CSR_DT_RAW6:     fmt = {4'h8, 7'h30};
			`CSR_DT_RAW7:     fmt = {4'h8, 7'h38};
			`CSR_DT_RAW8:     fmt = {4'h8, 7'h40};
			`CSR_DT_RAW10:    fmt = {4'h4, 7'h28};
			`CSR_DT_RAW12:    fmt = {4'h4, 7'h30};
			`CSR_DT_RAW14:    fmt = {4'h4, 7'h38};
			`CSR_DT_YUV420_8,
			`CSR_DT_YUV420_S: fmt = odd ? {4'h8, 7'h40} : {4'h4, 7'h40};
			`CSR_DT_YUV420_A,
			`CSR_DT_YUV420_T: fmt = odd ? {4'h4, 7'h28} : {4'h2, 7'h28};
			`CSR_DT_LEGACY8:  fmt = {4'h4, 7'h30};
			`CSR_DT_YUV422_8: fmt = {4'h4, 7'h40};
			`CSR_DT_YUV422_A: fmt = {4'h2, 7'h28};
			default:
				if (t >= `CSR_DT_USER_LO && t <= `CSR_DT_USER_HI)
					fmt = {4'h8, 7'h40};
				else
					fmt = {4'h8, 7'h40};
		endcase
	endfunction

	// ----------------------------------------
	// pixel packer
	// ----------------------------------------
	logic [AW-1:0]  acc_q, acc_d;
	logic [7:0]     fill_q, fill_d;
	csr_dtype_t     type_q, type_d;
	logic           hsync_q, hsync_d, odd_q, odd_d;
	logic [63:0]    pix_q, pix_d;
	logic           pv_q, pv_d;
	logic [3:0]     pc_q, pc_d;

	always_comb
	begin
		logic [10:0]   f;
		logic [AW-1:0] mask;
		logic [AW-1:0] add;
		logic [7:0]    addBits;
		f       = fmt(type_q, odd_q);
		mask    = '0;
		add     = '0;
		addBits = 8'h00;
		acc_d   = acc_q;
		fill_d  = fill_q;
		pix_d   = pix_q;
		pv_d    = 1'b0;
		pc_d    = pc_q;
		hsync_d = |laneActive;
		odd_d   = odd_q;
		// selector is only taken between lines
		type_d  = hsync_q ? type_q : typeSel;
		if (hsync_q && !hsync_d)
			odd_d = !odd_q;
		if (fill_q >= {1'b0, f[6:0]})
		begin
			mask  = ~({AW{1'b1}} << f[6:0]);
			pix_d = 64'(acc_q & mask);
			pv_d  = 1'b1;
			pc_d  = f[10:7];
			acc_d = acc_q >> f[6:0];
			fill_d = fill_q - {1'b0, f[6:0]};
		end
		for (int i = 0; i < LANES; i++)
			if (laneValid[i] && (laneValid & ((LANES'(1) << i) - LANES'(1))) ==
				((LANES'(1) << i) - LANES'(1)))
			begin
				add     = add | (AW'(laneByte[i]) << addBits);
				addBits = addBits + 8'h08;
			end
		acc_d  = acc_d | (add << fill_d);
		fill_d = fill_d + addBits;
		// a line that ends drops its partial pixel word
		if (!hsync_d)
		begin
			acc_d  = '0;
			fill_d = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			acc_q   <= '0;
			fill_q  <= 8'h00;
			type_q  <= `CSR_DT_RAW8;
			hsync_q <= 1'b0;
			odd_q   <= 1'b1;
			pix_q   <= 64'h0;
			pv_q    <= 1'b0;
			pc_q    <= 4'h0;
		end
		else if (ce)
		begin
			acc_q   <= acc_d;
			fill_q  <= fill_d;
			type_q  <= type_d;
			hsync_q <= hsync_d;
			odd_q   <= odd_d;
			pix_q   <= pix_d;
			pv_q    <= pv_d;
			pc_q    <= pc_d;
		end
	end

	// ----------------------------------------
	// error status and lane flags
	// ----------------------------------------
	logic [1:0] err_q, err_d;
	logic       clkHs_q, clkHs_d;

	always_comb
	begin
		err_d = errClear ? `CSR_ERR_RST : err_q;
		// a new error in the clear cycle still lands
		if (clkCtrlErr || |laneCtrlErr)
			err_d[`CSR_ERR_CTRL] = 1'b1;
		if (|laneSotErr)
			err_d[`CSR_ERR_SOT] = 1'b1;
		clkHs_d = clkActive;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			err_q   <= `CSR_ERR_RST;
			clkHs_q <= 1'b0;
		end
		else if (ce)
		begin
			err_q   <= err_d;
			clkHs_q <= clkHs_d;
		end
	end

	assign pixelData  = pix_q;
	assign pixelValid = pv_q;
	assign pixelCount = pc_q;
	assign hsync      = hsync_q;
	assign lineOdd    = odd_q;
	assign clkLaneHs  = clkHs_q;
	assign errStatus  = err_q;
endmodule

/* File: csr_rx_checker.sv */
`timescale 1ns/1ps
module csr_rx_checker #(
	parameter int LANES = 4
) (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire csr_pkg::csr_lp_t    clkLaneLp,
	input  wire logic [2*LANES-1:0]  dataLaneLp,
	input  wire csr_pkg::csr_dtype_t typeSel,
	input  wire logic                errClear,
	input  wire logic                pixelValid,
	input  wire logic [3:0]          pixelCount,
	input  wire logic                hsync,
	input  wire logic                lineOdd,
	input  wire logic                clkLaneHs,
	input  wire logic [1:0]          errStatus
);
	import csr_pkg::*;
	// cycles lane 0 has shown LP-00, saturating so it never wraps
	logic [7:0] zero_q;
	logic [7:0] zero_d;
	always_comb
	begin
		zero_d = (dataLaneLp[1:0] != 2'h0) ? 8'h00 : zero_q + {7'h00, zero_q != 8'hFF};
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			zero_q <= 8'h00;
		else
			zero_q <= zero_d;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_skip;
		dataLaneLp[1:0] == 2'h3 ##1 dataLaneLp[1:0] == 2'h0 |-> ##[1:6] errStatus[0];
	endproperty
	a_skip: assert property (p_skip) else $error("skipped request not flagged");
	property p_clkOff;
		(clkLaneLp == 2'h3)[*5] |-> !clkLaneHs;
	endproperty
	a_clkOff: assert property (p_clkOff) else $error("clock lane HS in stop state");
	property p_lineOff;
		(&dataLaneLp)[*5] |-> !hsync;
	endproperty
	a_lineOff: assert property (p_lineOff) else $error("hsync in stop state");
	property p_settle;
		$rose(clkLaneHs) |-> $past(clkLaneLp) == 2'h0 && $past(clkLaneLp, 2) == 2'h0;
	endproperty
	a_settle: assert property (p_settle) else $error("clock lane HS too early");
	property p_hunt;
		$rose(hsync) |-> zero_q >= 8'h19 && clkLaneHs;
	endproperty
	a_hunt: assert property (p_hunt) else $error("data taken inside settle");
	property p_odd;
		pixelValid && typeSel == 6'h1D && lineOdd |-> pixelCount == 4'h4;
	endproperty
	a_odd: assert property (p_odd) else $error("odd line count wrong");
	property p_even;
		pixelValid && typeSel == 6'h1D && !lineOdd |-> pixelCount == 4'h2;
	endproperty
	a_even: assert property (p_even) else $error("even line count wrong");
	property p_rgb;
		pixelValid && typeSel == 6'h24 |-> pixelCount == 4'h2;
	endproperty
	a_rgb: assert property (p_rgb) else $error("rgb888 count wrong");
	property p_sticky;
		$fell(errStatus[0]) || $fell(errStatus[1]) |-> $past(errClear);
	endproperty
	a_sticky: assert property (p_sticky) else $error("error fell without clear");
	c_line: cover property ($rose(hsync));
	c_word: cover property (pixelValid && pixelCount == 4'h4);
	c_err: cover property ($rose(errStatus[0]));
endmodule
bind csr_rx csr_rx_checker #(.LANES(LANES)) chk (.clk(clk), .arst_n(arst_n),
	.clkLaneLp(clkLaneLp), .dataLaneLp(dataLaneLp), .typeSel(typeSel), .errClear(errClear),
	.pixelValid(pixelValid), .pixelCount(pixelCount), .hsync(hsync), .lineOdd(lineOdd),
	.clkLaneHs(clkLaneHs), .errStatus(errStatus));

/* File: csr_tx_model.sv */
`timescale 1ns/1ps
`include "csr_defines.svh"
module csr_tx_model #(
	parameter int LANES = 4
) (
	output logic linkClk,
	output csr_pkg::csr_lp_t clkLaneLp,
	output logic [2*LANES-1:0] dataLaneLp,
	output logic [LANES-1:0] dataLaneHs
);
	import csr_pkg::*;
	localparam int UI = `CSR_UI_NS;
	initial
	begin
		linkClk = 1'b0;
		clkLaneLp = `CSR_LP11;
		dataLaneLp = '1;
		dataLaneHs = '0;
	end
	// bits change half an interval before the clock edge so the sampling edge never races them
	task automatic ui(input logic [LANES-1:0] bits);
		dataLaneHs = bits;
		#(UI / 2);
		linkClk = ~linkClk;
		#(UI / 2);
	endtask
	task automatic burst(input int nBytes, input logic [7:0] base);
		logic [7:0] b;
		logic [7:0] s;
		logic [LANES-1:0] bits;
		s = `CSR_SYNC;
		clkLaneLp = `CSR_LP01;
		#200;
		clkLaneLp = `CSR_LP00;
		#400;
		repeat (8) ui(~dataLaneHs);
		dataLaneLp = {LANES{`CSR_LP01}};
		#200;
		dataLaneLp = '0;
		repeat (12) ui('0);
		for (int i = 0; i < 8; i++)
			ui({LANES{s[i]}});
		for (int k = 0; k < nBytes; k++)
			for (int i = 0; i < 8; i++)
			begin
				for (int g = 0; g < LANES; g++)
				begin
					b = base + 8'(16 * k + g);
					bits[g] = b[i];
				end
				ui(bits);
			end
		// trail holds the inverse of the last payload bit; the receiver still
		// shifts it in, so it lands as one extra byte per lane
		bits = ~dataLaneHs;
		repeat (8) ui(bits);
		dataLaneLp = '1;
		repeat (4) ui(~dataLaneHs);
		#100;
		clkLaneLp = `CSR_LP11;
		dataLaneHs = ~dataLaneHs;
		#600;
	endtask
	// a burst whose data lanes fall back to stop before the sync byte
	task automatic cut_burst();
		clkLaneLp = `CSR_LP01;
		#200;
		clkLaneLp = `CSR_LP00;
		#400;
		repeat (8) ui(~dataLaneHs);
		dataLaneLp = {LANES{`CSR_LP01}};
		#200;
		dataLaneLp = '0;
		repeat (9) ui('0);
		dataLaneLp = '1;
		repeat (4) ui('0);
		#100;
		clkLaneLp = `CSR_LP11;
		#600;
	endtask
	task automatic skip_request();
		dataLaneLp = '0;
		#300;
		dataLaneLp = '1;
		#600;
	endtask
endmodule

/* File: csr_rx_test.sv */
`timescale 1ns/1ps
module csr_rx_test;
	import csr_pkg::*;
	logic clk = 1'b0;
	logic arst_n;
	logic ce;
	csr_dtype_t typeSel;
	logic errClear;
	logic linkClk;
	csr_lp_t clkLaneLp;
	logic [7:0] dataLaneLp;
	logic [3:0] dataLaneHs;
	logic [63:0] pixelData;
	logic pixelValid;
	logic [3:0] pixelCount;
	logic hsync;
	logic lineOdd;
	logic clkLaneHs;
	logic [1:0] errStatus;
	logic [63:0] firstWord;
	logic [3:0] firstCount;
	logic clkSeen;
	int words;
	int err_total = 0;
	int comparisons = 0;

	always #50 clk = ~clk;

	csr_rx #(.LANES(4)) dut (.clk(clk), .arst_n(arst_n), .ce(ce), .linkClk(linkClk),
		.clkLaneLp(clkLaneLp), .dataLaneLp(dataLaneLp), .dataLaneHs(dataLaneHs),
		.typeSel(typeSel), .errClear(errClear), .pixelData(pixelData), .pixelValid(pixelValid),
		.pixelCount(pixelCount), .hsync(hsync), .lineOdd(lineOdd), .clkLaneHs(clkLaneHs),
		.errStatus(errStatus));
	csr_tx_model #(.LANES(4)) tx (.linkClk(linkClk), .clkLaneLp(clkLaneLp),
		.dataLaneLp(dataLaneLp), .dataLaneHs(dataLaneHs));

	// outputs are settled half a cycle after the edge that launches them
	always @(negedge clk)
	begin
		if (clkLaneHs === 1'b1)
			clkSeen = 1'b1;
		if (pixelValid === 1'b1)
		begin
			if (words == 0)
			begin
				firstWord = pixelData;
				firstCount = pixelCount;
			end
			words++;
		end
	end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic test_reset();
		check("idle flags", 64'({pixelValid, hsync, lineOdd, clkLaneHs, errStatus, pixelCount}),
			64'h80);
		check("idle data", pixelData, 64'h0);
	endtask

	task automatic test_ctrl_err();
		tx.skip_request();
		check("control error", 64'(errStatus), 64'h1);
		check("no line", 64'(hsync), 64'h0);
		tx.cut_burst();
		check("sync error", 64'(errStatus), 64'h3);
		check("no line after cut", 64'(hsync), 64'h0);
		// a clear while the clock enable is low must not land
		@(negedge clk);
		ce = 1'b0;
		errClear = 1'b1;
		repeat (2) @(negedge clk);
		check("frozen", 64'(errStatus), 64'h3);
		ce = 1'b1;
		repeat (2) @(negedge clk);
		errClear = 1'b0;
		@(negedge clk);
		check("cleared", 64'(errStatus), 64'h0);
	endtask

	// one burst of four bytes per lane; the lane byte is base + 16*index + lane
	task automatic run_line(input csr_dtype_t code, input logic [63:0] expWord,
		input logic [63:0] mask, input logic [3:0] expCount, input int expWords, input logic odd);
		@(negedge clk);
		typeSel = code;
		words = 0;
		clkSeen = 1'b0;
		check("lineOdd", 64'(lineOdd), 64'(odd));
		tx.burst(4, 8'h01);
		check("clkLaneHs", 64'(clkSeen), 64'h1);
		check("words", 64'(words), 64'(expWords));
		check("pixelCount", 64'(firstCount), 64'(expCount));
		check("pixelData", firstWord & mask, expWord);
		check("hsync", 64'(hsync), 64'h0);
	endtask

	// word counts include the trail byte: 160 bits give four 40-bit and three 48-bit words
	task automatic test_odd_line();
		run_line(6'h1D, 64'h11_0403_0201, 64'hFF_FFFF_FFFF, 4'h4, 4, 1'b1);
	endtask

	task automatic test_even_line();
		run_line(6'h1D, 64'h11_0403_0201, 64'hFF_FFFF_FFFF, 4'h2, 4, 1'b0);
	endtask

	task automatic test_rgb888();
		run_line(6'h24, 64'h1211_0403_0201, 64'hFFFF_FFFF_FFFF, 4'h2, 3, 1'b1);
	endtask

	// the scenarios need about 104 us; nearly four times that is a hang
	initial
	begin
		#400000;
		err_total++;
		end_of_test();
	end

	initial
	begin
		arst_n = 1'b0;
		ce = 1'b1;
		typeSel = 6'h2A;
		errClear = 1'b0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		repeat (2) @(negedge clk);
		test_reset();
		test_ctrl_err();
		test_odd_line();
		test_even_line();
		test_rgb888();
		end_of_test();
	end
endmodule
